// ### src/ssb_pkg.sv
/*
  constants and types shared by the sector segmentation buffer.
  assumes a 32-bit read bus on the processor side and a 16-bit sector link.
*/
package ssb_pkg;

  // ************************************************************
  // sector layout on the sector link, in 16-bit words
  // ************************************************************
  localparam int SSB_MAIN_HALVES = 1176;
  localparam int SSB_FLAG_HALVES = 148;
  localparam int SSB_SUBC_HALVES = 57;
  localparam int SSB_STAT_HALVES = 2;
  localparam int SSB_CNT_W = 11;

  // ************************************************************
  // buffer geometry
  // ************************************************************
  localparam int SSB_BUF_WORDS = 692;
  localparam int SSB_ADDR_W = 10;
  localparam int SSB_HALF_W = 16;
  localparam int SSB_WORD_W = 32;
  localparam int SSB_FIFO_DEPTH = 8;
  localparam int SSB_BUS_ADDR_W = 12;
  localparam int SSB_WORD_LSB = 2;

  // ************************************************************
  // processor bus encodings and reset values
  // ************************************************************
  localparam logic [1:0] SSB_HTRANS_NONSEQ = 2'h2;
  localparam logic SSB_HRESP_OKAY = 1'h0;
  localparam logic SSB_HRESP_ERROR = 1'h1;
  localparam logic SSB_HREADY_RST = 1'h1;
  localparam logic [SSB_WORD_W-1:0] SSB_HRDATA_RST = 32'h0;

  // bus data phase state
  typedef enum logic [0:0] {
    SSB_BUS_OKAY,
    SSB_BUS_ERR2
  } ssb_bus_state_t;

endpackage : ssb_pkg

// ### src/ssb_top.sv
/*
  sector segmentation buffer: word fifo and the top level with sync, packer,
  sector memory, interrupt and processor bus read slave.
  assumes the sector link sender holds data stable until its next toggle and
  that the bus master keeps to single-word reads with hready_in.
*/
// What this block does
// - sector link is asynchronous; all handshake crossings are synchronised.
// - one link burst carries exactly one complete sector into the buffer.
// - sender toggles request per half; one half captured per detected toggle.
// - order: 1176 main, optional 148 flags, optional 57 subcode, two status.
// - buffer is bus readable only after the whole sector was written.
// - owner select steers buffer access to link write or bus read side.
// - link side only writes buffer; bus side only reads it.
// - buffer is 692 words of 32 bits, holding the largest sector.
// - interrupt raised from memory full on every completed sector.
// - interrupt held until cleared, then free to fire on next sector.
// - clear bit keeps last write; 0 clears, a later 1 leaves it cleared.
// - bus reads served as a synchronous zero-wait slave.
`timescale 1ns/100ps

// ************************************************************
// word fifo between packer and sector memory
// ************************************************************
module ssb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
  } ssb_fifo_state_t;

  ssb_fifo_state_t st_reg;
  ssb_fifo_state_t st_next;
  logic full;
  logic empty;

  // honest flags from pointer compare
  assign empty = (st_reg.wr_ptr == st_reg.rd_ptr);
  assign full = (st_reg.wr_ptr[PW-1:0] == st_reg.rd_ptr[PW-1:0]) && (st_reg.wr_ptr[PW] != st_reg.rd_ptr[PW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_reg.mem[st_reg.rd_ptr[PW-1:0]];

  // push and pop
  always_comb begin
    st_next = st_reg;
    if (in_valid && !full) begin
      st_next.mem[st_reg.wr_ptr[PW-1:0]] = in_data;
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : ssb_fifo

// ************************************************************
// top level
// ************************************************************
module ssb_top (
  input wire logic clk,
  input wire logic rst_n,
  // sector link, asynchronous to clk
  input wire logic link_req_toggle,
  input wire logic [ssb_pkg::SSB_HALF_W-1:0] link_data,
  output logic link_ready,
  // control and status bits
  input wire logic owner_bus_sel,
  input wire logic flags_enable,
  input wire logic subcode_enable,
  input wire logic irq_clr_n,
  output logic sector_irq,
  output logic memory_full,
  output logic link_overrun,
  // processor bus read slave
  input wire logic hsel,
  input wire logic [ssb_pkg::SSB_BUS_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready_in,
  output logic [ssb_pkg::SSB_WORD_W-1:0] hrdata,
  output logic hready_out,
  output logic hresp
);
  import ssb_pkg::*;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic req_lvl;
    logic [SSB_HALF_W-1:0] dat_s1;
    logic [SSB_HALF_W-1:0] dat_s2;
    logic [SSB_HALF_W-1:0] dat_s3;
    logic [SSB_CNT_W-1:0] half_cnt;
    logic [SSB_HALF_W-1:0] lo_half;
    logic have_lo;
    logic push_valid;
    logic [SSB_WORD_W-1:0] push_data;
    logic [SSB_ADDR_W-1:0] wptr;
    logic mem_full;
    logic full_seen;
    logic owner_d;
    logic irq;
    logic overrun;
    logic link_rdy;
    logic [SSB_WORD_W-1:0] rdata;
    logic hready;
    logic hresp;
    ssb_bus_state_t bus_state;
  } ssb_state_t;

  ssb_state_t st_reg;
  ssb_state_t st_next;
  logic [1:0] rst_pipe_reg;
  logic rst_sync_n;
  logic [SSB_WORD_W-1:0] buf_mem [SSB_BUF_WORDS];
  logic fifo_in_ready;
  logic [SSB_WORD_W-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [SSB_CNT_W-1:0] sector_halves;
  logic [SSB_CNT_W-1:0] sector_words;
  logic req_edge;
  logic last_half;
  logic mem_we;
  logic bus_req;
  logic [SSB_ADDR_W-1:0] rd_index;

  // ************************************************************
  // reset release
  // ************************************************************

  // async assert, release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  // ************************************************************
  // sector length and link edge detect
  // ************************************************************

  // burst size follows the same option bits the sender uses
  assign sector_halves = SSB_CNT_W'(SSB_MAIN_HALVES + SSB_STAT_HALVES)
    + (flags_enable ? SSB_CNT_W'(SSB_FLAG_HALVES) : '0)
    + (subcode_enable ? SSB_CNT_W'(SSB_SUBC_HALVES) : '0);
  assign sector_words = SSB_CNT_W'((sector_halves + 1'b1) >> 1);

  // a toggle counts once stages two and three agree on a new level
  assign req_edge = (st_reg.req_s2 == st_reg.req_s3) && (st_reg.req_s3 != st_reg.req_lvl);
  assign last_half = (st_reg.half_cnt == sector_halves - 1'b1);

  // drain into memory only while the link side owns it
  assign fifo_out_ready = !owner_bus_sel && !st_reg.mem_full;
  assign mem_we = fifo_out_valid && fifo_out_ready;

  // ************************************************************
  // word fifo
  // ************************************************************
  ssb_fifo #(
    .WIDTH(SSB_WORD_W),
    .DEPTH(SSB_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_sync_n),
    .in_data(st_reg.push_data),
    .in_valid(st_reg.push_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // ************************************************************
  // sector memory
  // ************************************************************

  // write port from the fifo only; no reset on the array
  always_ff @(posedge clk) begin
    if (mem_we) begin
      buf_mem[st_reg.wptr] <= fifo_out_data;
    end
  end

  // a transfer is taken in its address phase while the slave shows ready
  assign bus_req = hsel && htrans[1] && hready_in && st_reg.hready;
  assign rd_index = haddr[SSB_WORD_LSB +: SSB_ADDR_W];

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.push_valid = 1'b0;
    st_next.owner_d = owner_bus_sel;

    // three-stage sampling of the link pins
    st_next.req_s1 = link_req_toggle;
    st_next.req_s2 = st_reg.req_s1;
    st_next.req_s3 = st_reg.req_s2;
    st_next.dat_s1 = link_data;
    st_next.dat_s2 = st_reg.dat_s1;
    st_next.dat_s3 = st_reg.dat_s2;

    // each toggle delivers one half; two halves make a word
    if (req_edge) begin
      st_next.req_lvl = st_reg.req_s3;
      if (st_reg.half_cnt < sector_halves) begin
        st_next.half_cnt = st_reg.half_cnt + 1'b1;
        if (st_reg.have_lo) begin
          st_next.push_valid = 1'b1;
          st_next.push_data = {st_reg.dat_s3, st_reg.lo_half};
          st_next.have_lo = 1'b0;
        end else if (last_half) begin
          st_next.push_valid = 1'b1;
          st_next.push_data = {16'h0, st_reg.dat_s3}; // odd tail, upper half zero
        end else begin
          st_next.lo_half = st_reg.dat_s3;
          st_next.have_lo = 1'b1;
        end
      end
    end

    // ready to the sender only while no push is pending
    st_next.link_rdy = fifo_in_ready && !st_next.push_valid;

    // memory write pointer and full detect
    if (mem_we) begin
      st_next.wptr = st_reg.wptr + 1'b1;
      if (SSB_CNT_W'(st_reg.wptr) == sector_words - 1'b1) begin
        st_next.mem_full = 1'b1;
      end
    end

    // handing ownership back to the link starts a new sector
    if (st_reg.owner_d && !owner_bus_sel) begin
      st_next.half_cnt = '0;
      st_next.have_lo = 1'b0;
      st_next.wptr = '0;
      st_next.mem_full = 1'b0;
      st_next.overrun = 1'b0;
      // words still queued from a cut sector are not flushed
    end

    // a push the fifo cannot take is lost and flagged; the set beats the
    // restart clear so that a loss in that very cycle still shows
    if (st_reg.push_valid && !fifo_in_ready) begin
      st_next.overrun = 1'b1;
    end

    // interrupt on each rising memory full; set beats clear
    st_next.full_seen = st_reg.mem_full;
    if (!irq_clr_n) begin
      st_next.irq = 1'b0;
    end
    if (st_reg.mem_full && !st_reg.full_seen) begin
      st_next.irq = 1'b1;
    end

    // bus slave: zero-wait reads, two-cycle error otherwise
    case (st_reg.bus_state)
      SSB_BUS_OKAY: begin
        st_next.hready = 1'b1;
        st_next.hresp = SSB_HRESP_OKAY;
        if (bus_req) begin
          if (hwrite || !owner_bus_sel || !st_reg.mem_full) begin
            st_next.hready = 1'b0;
            st_next.hresp = SSB_HRESP_ERROR;
            st_next.bus_state = SSB_BUS_ERR2;
          end else if (SSB_CNT_W'(rd_index) < SSB_CNT_W'(SSB_BUF_WORDS)) begin
            st_next.rdata = buf_mem[rd_index];
          end else begin
            st_next.rdata = '0;
          end
        end
      end
      SSB_BUS_ERR2: begin
        st_next.hready = 1'b1;
        st_next.hresp = SSB_HRESP_ERROR;
        st_next.bus_state = SSB_BUS_OKAY;
      end
      default: begin
        st_next.bus_state = SSB_BUS_OKAY;
      end
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= '0;
      st_reg.hready <= SSB_HREADY_RST;
      st_reg.hresp <= SSB_HRESP_OKAY;
      st_reg.rdata <= SSB_HRDATA_RST;
      st_reg.bus_state <= SSB_BUS_OKAY;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign link_ready = st_reg.link_rdy;
  assign sector_irq = st_reg.irq;
  assign memory_full = st_reg.mem_full;
  assign link_overrun = st_reg.overrun;
  assign hrdata = st_reg.rdata;
  assign hready_out = st_reg.hready;
  assign hresp = st_reg.hresp;
endmodule : ssb_top

// ### verification/ssb_sender_model.sv
/*
  sender model: plays one sector per start pulse onto the sector link.
  assumes the buffer samples data some clk edges after each toggle.
*/
`timescale 1ns/100ps
module ssb_sender_model
  import ssb_pkg::*;
(
  input wire logic start,
  input wire logic link_ready,
  input wire logic flags_enable,
  input wire logic subcode_enable,
  input wire logic [15:0] seed,
  output logic link_req_toggle,
  output logic [15:0] link_data
);
  int n;
  // free running timing, no relation to clk phase
  initial begin
    link_req_toggle = 1'b0;
    link_data = 16'h0;
    forever begin
      @(posedge start);
      #3;
      n = SSB_MAIN_HALVES + SSB_STAT_HALVES;
      n += (flags_enable ? SSB_FLAG_HALVES : 0) + (subcode_enable ? SSB_SUBC_HALVES : 0);
      for (int i = 0; i < n; i++) begin
        while (link_ready !== 1'b1) #13;
        link_data = 16'(i * 37) ^ seed;
        link_req_toggle = ~link_req_toggle;
        #60;
      end
      // no pull on the data lines: show garbage once released
      link_data = ~link_data;
    end
  end
endmodule : ssb_sender_model

// ### verification/ssb_top_checker.sv
/*
  port checker for the sector buffer: interrupt and bus answers.
  assumes the single clk domain and the raw rst_n.
*/
`timescale 1ns/100ps
module ssb_top_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic owner_bus_sel,
  input wire logic irq_clr_n,
  input wire logic sector_irq,
  input wire logic memory_full,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready_in,
  input wire logic [ssb_pkg::SSB_WORD_W-1:0] hrdata,
  input wire logic hready_out,
  input wire logic hresp
);
  import ssb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  // address phase taken by the slave
  assign take = hsel && htrans[1] && hready_in && hready_out;
  sequence s_err;
    !hready_out && hresp ##1 hready_out && hresp;
  endsequence
  sequence s_ok;
    hready_out && hresp == SSB_HRESP_OKAY;
  endsequence
  a_irq_on_full: assert property ($rose(memory_full) |=> sector_irq)
    else $error("interrupt missing after sector");
  a_irq_held: assert property (sector_irq && irq_clr_n |=> sector_irq)
    else $error("interrupt dropped without clear");
  a_irq_cleared: assert property (!irq_clr_n && !$rose(memory_full) |=> !sector_irq)
    else $error("interrupt not cleared");
  a_read_served: assert property (take && !hwrite && owner_bus_sel && memory_full |=> s_ok)
    else $error("read not served at once");
  a_early_refused: assert property (take && !hwrite && !memory_full |=> s_err)
    else $error("read before sector end accepted");
  a_write_refused: assert property (take && hwrite |=> s_err)
    else $error("bus write accepted");
  a_owner_refused: assert property (take && !owner_bus_sel |=> s_err)
    else $error("bus access while link owns buffer");
  a_new_sector: assert property ($fell(owner_bus_sel) |=> !memory_full)
    else $error("full kept into new sector");
  a_data_held: assert property (!take |=> $stable(hrdata))
    else $error("read data moved without access");
endmodule : ssb_top_checker
bind ssb_top ssb_top_checker ssb_top_checker_inst (.clk(clk), .rst_n(rst_n),
  .owner_bus_sel(owner_bus_sel), .irq_clr_n(irq_clr_n), .sector_irq(sector_irq),
  .memory_full(memory_full), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready_in(hready_in), .hrdata(hrdata), .hready_out(hready_out), .hresp(hresp));

// ### verification/ssb_top_test.sv
/*
  testbench: random sectors through the link, bus reads and interrupt clear.
  assumes the package, design, sender model and checker are compiled first.
*/
`timescale 1ns/100ps
module ssb_top_test;
  import ssb_pkg::*;
  logic clk, rst_n, tog, ready, owner, fen, sen, clr_n, irq, full, ovr, start;
  logic hsel, hwrite, hready_out, hresp, r;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [15:0] ldata, seed;
  logic [31:0] hrdata, d;
  int error_cnt = 0;
  int comparisons = 0;
  int n, w, idx;
  ssb_top ssb_top_inst (.clk(clk), .rst_n(rst_n), .link_req_toggle(tog), .link_data(ldata),
    .link_ready(ready), .owner_bus_sel(owner), .flags_enable(fen), .subcode_enable(sen),
    .irq_clr_n(clr_n), .sector_irq(irq), .memory_full(full), .link_overrun(ovr), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready_in(hready_out), .hrdata(hrdata),
    .hready_out(hready_out), .hresp(hresp));
  ssb_sender_model ssb_sender_model_inst (.start(start), .link_ready(ready), .flags_enable(fen),
    .subcode_enable(sen), .seed(seed), .link_req_toggle(tog), .link_data(ldata));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one bus transfer, waits out a two cycle error answer
  task automatic bus(input int i, input logic wr);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= SSB_HTRANS_NONSEQ;
    haddr <= {10'(i), 2'h0};
    hwrite <= wr;
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    #1;
    if (hready_out !== 1'b1) @(posedge clk) #1;
    d = hrdata;
    r = hresp;
  endtask : bus
  // dma style drain: back-to-back reads from word 0 up to the sector boundary
  task automatic burst(input int words);
    for (int k = 0; k <= words; k++) begin
      @(posedge clk);
      hsel <= (k < words);
      htrans <= (k < words) ? SSB_HTRANS_NONSEQ : 2'h0;
      hwrite <= 1'b0;
      haddr <= {10'(k), 2'h0};
      #1;
      if (k > 0) check(hrdata, exp_word(k - 1));
    end
  endtask : burst
  // expected word: first half low, odd last half padded
  function automatic logic [31:0] exp_word(input int k);
    logic [15:0] lo, hi;
    lo = 16'(2 * k * 37) ^ seed;
    hi = (2 * k + 1 < n) ? 16'((2 * k + 1) * 37) ^ seed : 16'h0;
    return (k >= SSB_BUF_WORDS) ? 32'h0 : {hi, lo};
  endfunction : exp_word
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watchdog: four sectors of about 71 to 83 us each
  initial begin
    #500000;
    error_cnt++;
    final_report();
  end
  initial begin
    {rst_n, fen, sen, start, hsel, hwrite, haddr, htrans, seed} = '0;
    {owner, clr_n} = 2'h3;
    void'($urandom(32'h39f8));
    repeat (8) @(posedge clk);
    #1 check(32'({irq, full, ovr, ready, hready_out, hresp}), 32'h2);
    check(hrdata, SSB_HRDATA_RST);
    @(posedge clk) rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int s = 0; s < 4; s++) begin
      {fen, sen} <= 2'(3 - s); // all four option mixes
      seed <= 16'($urandom);
      owner <= 1'b0;
      @(posedge clk);
      bus(0, 1'b0);
      check(32'(r), 32'(SSB_HRESP_ERROR));
      @(posedge clk) start <= 1'b1;
      n = SSB_MAIN_HALVES + SSB_STAT_HALVES + (fen ? SSB_FLAG_HALVES : 0) + (sen ? SSB_SUBC_HALVES : 0);
      w = (n + 1) / 2;
      for (int i = 0; i < 14000 && full !== 1'b1; i++) @(posedge clk) #1;
      check(32'(full), 32'h1);
      @(posedge clk) start <= 1'b0;
      #1 check(32'(irq), 32'h1);
      bus(1, 1'b0);
      check(32'(r), 32'(SSB_HRESP_ERROR));
      @(posedge clk) owner <= 1'b1;
      for (int k = 0; k < 7; k++) begin
        idx = (k == 0) ? 0 : (k == 1) ? w - 1 : (k == 6) ? SSB_BUF_WORDS : $urandom_range(w - 1);
        bus(idx, 1'b0);
        check(d, exp_word(idx));
        check(32'(r), 32'(SSB_HRESP_OKAY));
      end
      burst(w);
      bus(2, 1'b1);
      check(32'(r), 32'(SSB_HRESP_ERROR));
      @(posedge clk) clr_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check(32'(irq), 32'h0);
      @(posedge clk) clr_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check(32'({irq, ovr}), 32'h0);
      $display("test sector %0d done", s);
      @(posedge clk);
    end
    final_report();
  end
endmodule : ssb_top_test
